// ===== tsirq_defs.svh
`ifndef TSIRQ_DEFS_SVH
`define TSIRQ_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define TSIRQ_ADDR_W 10
`define TSIRQ_DATA_W 16
`define TSIRQ_STAGES 12
`define TSIRQ_OFF_LOW_EN 10'h005
`define TSIRQ_OFF_HIGH_EN 10'h006
`define TSIRQ_OFF_DONE_EN 10'h007
`define TSIRQ_OFF_LOW_ST 10'h008
`define TSIRQ_OFF_HIGH_ST 10'h009
`define TSIRQ_OFF_DONE_ST 10'h00A

// ****************************************
// field positions
// ****************************************
`define TSIRQ_STAGE_HI 11
`define TSIRQ_PIN_EN_BIT 12
`define TSIRQ_PIN_ST_BIT 12
`define TSIRQ_SETUP_HI 13
`define TSIRQ_SETUP_LO 12
`define TSIRQ_TRIG_HI 15
`define TSIRQ_TRIG_LO 14

// ****************************************
// reset values
// ****************************************
`define TSIRQ_RST_WORD 16'h0000
`define TSIRQ_RST_STAGE 12'h000

`endif

// ===== tsirq_pkg.sv
`include "tsirq_defs.svh"

package tsirq_pkg;

	// ****************************************
	// pin setup and trigger encodings
	// ****************************************
	typedef enum logic [1:0] {
		TSIRQ_PIN_OFF = 2'h0,
		TSIRQ_PIN_IN = 2'h1,
		TSIRQ_PIN_LOW = 2'h2,
		TSIRQ_PIN_HIGH = 2'h3
	} tsirq_setup_t;

	typedef enum logic [1:0] {
		TSIRQ_TRIG_NEG_LVL = 2'h0,
		TSIRQ_TRIG_POS_EDGE = 2'h1,
		TSIRQ_TRIG_NEG_EDGE = 2'h2,
		TSIRQ_TRIG_POS_LVL = 2'h3
	} tsirq_trig_t;

	// ****************************************
	// register access from the serial front end
	// ****************************************
	typedef struct packed {
		logic [`TSIRQ_ADDR_W-1:0] addr;
		logic wr;
		logic rd;
		logic [`TSIRQ_DATA_W-1:0] wdata;
	} tsirq_req_t;

	// ****************************************
	// per-stage events from the sequencer
	// ****************************************
	typedef struct packed {
		logic [`TSIRQ_STAGES-1:0] done;
		logic [`TSIRQ_STAGES-1:0] low_act;
		logic [`TSIRQ_STAGES-1:0] high_act;
	} tsirq_evt_t;

endpackage

// ===== tsirq_top.sv
`include "tsirq_defs.svh"

// How it works
// - three sources, done, touch and pin, merge onto one interrupt line
// - interrupt line is open drain: only pulls low, else released
// - read address setup clears status and releases the line at once
// - enabled stage completing drives the line low
// - done-enable register holds one enable bit per stage
// - done status sets on fire; read clears only if cause gone
// - touch mode interrupts on touch and again on release
// - low and high touch enables sit in two registers
// - low and high touch status readable, one bit per stage
// - touch interrupt holds the line until touch status is read
// - any change in enabled touch bits raises a touch interrupt
// - touch status read gives current activation, not history
// - pin interrupts only while its setup field selects input
// - one pin interrupt enable bit lives in done-enable register
// - pin status bit in done-status register reads 1 once triggered
// - read clears pin status only when its cause has gone
// - trigger 00: low level holds line low and status set
// - trigger 01: rising edge sets status and holds line low until read
// - trigger 10: falling edge sets status and holds line low until read
// - trigger 11: high level holds line low and status set
// - pin setup field: 00 off, 01 input, 10 low, 11 high
module tsirq_top (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire tsirq_pkg::tsirq_req_t i_req,
	output logic [`TSIRQ_DATA_W-1:0] o_rd_data,
	input wire tsirq_pkg::tsirq_evt_t i_evt,
	input wire logic i_pin_i,
	output logic o_pin_o,
	output logic o_pin_oe,
	output logic o_int_n_o,
	output logic o_int_n_oe
);
	import tsirq_pkg::*;

	function automatic logic hit(input tsirq_req_t r, input logic [`TSIRQ_ADDR_W-1:0] off);
		hit = (r.addr == off);
	endfunction

	// ****************************************
	// enable registers
	// ****************************************
	logic [`TSIRQ_DATA_W-1:0] low_en_reg;
	logic [`TSIRQ_DATA_W-1:0] high_en_reg;
	logic [`TSIRQ_DATA_W-1:0] done_en_reg;

	// ****************************************
	// register write strobes
	// ****************************************
	logic wr_low_en;
	logic wr_high_en;
	logic wr_done_en;
	assign wr_low_en = i_req.wr & hit(i_req, `TSIRQ_OFF_LOW_EN);
	assign wr_high_en = i_req.wr & hit(i_req, `TSIRQ_OFF_HIGH_EN);
	assign wr_done_en = i_req.wr & hit(i_req, `TSIRQ_OFF_DONE_EN);

	// ****************************************
	// low limit enable, pin setup and trigger
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			low_en_reg <= `TSIRQ_RST_WORD;
		end else if (wr_low_en) begin
			low_en_reg <= i_req.wdata;
		end
	end

	// ****************************************
	// high limit enable
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			high_en_reg <= `TSIRQ_RST_WORD;
		end else if (wr_high_en) begin
			high_en_reg <= i_req.wdata;
		end
	end

	// ****************************************
	// stage done and pin enable
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			done_en_reg <= `TSIRQ_RST_WORD;
		end else if (wr_done_en) begin
			done_en_reg <= i_req.wdata;
		end
	end

	// ****************************************
	// enable field decode
	// ****************************************
	tsirq_setup_t setup;
	tsirq_trig_t trig;
	logic [`TSIRQ_STAGES-1:0] done_en;
	logic pin_en;
	assign setup = tsirq_setup_t'(low_en_reg[`TSIRQ_SETUP_HI:`TSIRQ_SETUP_LO]);
	assign trig = tsirq_trig_t'(low_en_reg[`TSIRQ_TRIG_HI:`TSIRQ_TRIG_LO]);
	assign done_en = done_en_reg[`TSIRQ_STAGE_HI:0];
	assign pin_en = done_en_reg[`TSIRQ_PIN_EN_BIT];

	// ****************************************
	// pin synchroniser and trigger detect
	// ****************************************
	logic pin_meta_reg;
	logic pin_sync_reg;
	logic pin_prev_reg;

	// ****************************************
	// pin first stage
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pin_meta_reg <= 1'b0;
		end else begin
			pin_meta_reg <= i_pin_i;
		end
	end

	// ****************************************
	// pin second stage
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pin_sync_reg <= 1'b0;
		end else begin
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// ****************************************
	// pin edge history
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pin_prev_reg <= 1'b0;
		end else begin
			pin_prev_reg <= pin_sync_reg;
		end
	end

	logic pin_cond;
	always_comb begin
		case (trig)
			TSIRQ_TRIG_NEG_LVL: pin_cond = ~pin_sync_reg;
			TSIRQ_TRIG_POS_EDGE: pin_cond = pin_sync_reg & ~pin_prev_reg;
			TSIRQ_TRIG_NEG_EDGE: pin_cond = ~pin_sync_reg & pin_prev_reg;
			TSIRQ_TRIG_POS_LVL: pin_cond = pin_sync_reg;
			default: pin_cond = 1'b0;
		endcase
	end

	// ****************************************
	// pin trigger qualify
	// ****************************************
	logic pin_is_input;
	logic pin_fire;
	assign pin_is_input = (setup == TSIRQ_PIN_IN);
	assign pin_fire = pin_cond & pin_en & pin_is_input;

	// ****************************************
	// pin output drive
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_pin_o <= 1'b0;
		end else begin
			o_pin_o <= (setup == TSIRQ_PIN_HIGH);
		end
	end

	// ****************************************
	// pin output enable
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_pin_oe <= 1'b0;
		end else begin
			o_pin_oe <= (setup == TSIRQ_PIN_LOW) | (setup == TSIRQ_PIN_HIGH);
		end
	end

	// ****************************************
	// clearing reads
	// ****************************************
	logic rd_low_st;
	logic rd_high_st;
	logic rd_done;
	logic rd_touch;
	assign rd_low_st = i_req.rd & hit(i_req, `TSIRQ_OFF_LOW_ST);
	assign rd_high_st = i_req.rd & hit(i_req, `TSIRQ_OFF_HIGH_ST);
	assign rd_done = i_req.rd & hit(i_req, `TSIRQ_OFF_DONE_ST);
	assign rd_touch = rd_low_st | rd_high_st;

	// ****************************************
	// done and pin status
	// ****************************************
	logic [`TSIRQ_STAGES-1:0] done_st_reg;
	logic [`TSIRQ_STAGES-1:0] done_fire;
	logic pin_st_reg;

	// ****************************************
	// stage done qualify
	// ****************************************
	assign done_fire = i_evt.done & done_en;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			done_st_reg <= `TSIRQ_RST_STAGE;
		end else if (rd_done) begin
			done_st_reg <= done_fire;
		end else begin
			done_st_reg <= done_st_reg | done_fire;
		end
	end

	// ****************************************
	// pin status
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pin_st_reg <= 1'b0;
		end else if (rd_done) begin
			pin_st_reg <= pin_fire;
		end else begin
			pin_st_reg <= pin_st_reg | pin_fire;
		end
	end

	// ****************************************
	// touch change detect
	// ****************************************
	logic [`TSIRQ_STAGES-1:0] low_seen_reg;
	logic [`TSIRQ_STAGES-1:0] high_seen_reg;
	logic [`TSIRQ_STAGES-1:0] low_now;
	logic [`TSIRQ_STAGES-1:0] high_now;
	logic touch_change;
	logic touch_pend_reg;

	// ****************************************
	// enabled touch levels
	// ****************************************
	assign low_now = i_evt.low_act & low_en_reg[`TSIRQ_STAGE_HI:0];
	assign high_now = i_evt.high_act & high_en_reg[`TSIRQ_STAGE_HI:0];
	assign touch_change = (low_now != low_seen_reg) | (high_now != high_seen_reg);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			low_seen_reg <= `TSIRQ_RST_STAGE;
		end else begin
			low_seen_reg <= low_now;
		end
	end

	// ****************************************
	// high limit history
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			high_seen_reg <= `TSIRQ_RST_STAGE;
		end else begin
			high_seen_reg <= high_now;
		end
	end

	// ****************************************
	// touch pending
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			touch_pend_reg <= 1'b0;
		end else if (touch_change) begin
			touch_pend_reg <= 1'b1;
		end else if (rd_touch) begin
			touch_pend_reg <= 1'b0;
		end
	end

	// ****************************************
	// interrupt line
	// ****************************************
	logic done_pend;
	logic pin_pend;
	logic touch_pend;
	logic pend;
	assign done_pend = |((done_st_reg | done_fire) & done_en);
	assign pin_pend = (pin_st_reg | pin_fire) & pin_en;
	assign touch_pend = touch_pend_reg | touch_change;
	assign pend = done_pend | pin_pend | touch_pend;

	// ****************************************
	// interrupt line drive
	// ****************************************
	assign o_int_n_o = 1'b0;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_int_n_oe <= 1'b0;
		end else begin
			o_int_n_oe <= pend & ~(rd_done | rd_touch);
		end
	end

	// ****************************************
	// read data
	// ****************************************
	logic [`TSIRQ_DATA_W-1:0] low_st_word;
	logic [`TSIRQ_DATA_W-1:0] high_st_word;
	logic [`TSIRQ_DATA_W-1:0] done_st_word;
	logic [`TSIRQ_DATA_W-1:0] rd_data_next;
	assign low_st_word = {4'h0, i_evt.low_act};
	assign high_st_word = {4'h0, i_evt.high_act};
	assign done_st_word = {3'h0, pin_st_reg, done_st_reg};

	// ****************************************
	// read data select
	// ****************************************
	always_comb begin
		rd_data_next = `TSIRQ_RST_WORD;
		case (i_req.addr)
			`TSIRQ_OFF_LOW_EN: rd_data_next = low_en_reg;
			`TSIRQ_OFF_HIGH_EN: rd_data_next = high_en_reg;
			`TSIRQ_OFF_DONE_EN: rd_data_next = done_en_reg;
			`TSIRQ_OFF_LOW_ST: rd_data_next = low_st_word;
			`TSIRQ_OFF_HIGH_ST: rd_data_next = high_st_word;
			`TSIRQ_OFF_DONE_ST: rd_data_next = done_st_word;
			default: rd_data_next = `TSIRQ_RST_WORD;
		endcase
	end

	// ****************************************
	// read data register
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rd_data <= `TSIRQ_RST_WORD;
		end else if (i_req.rd) begin
			o_rd_data <= rd_data_next;
		end
	end

endmodule // tsirq_top

// ===== tsirq_monitor.sv
module tsirq_monitor (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire tsirq_pkg::tsirq_req_t i_req,
	input wire logic [15:0] o_rd_data,
	input wire tsirq_pkg::tsirq_evt_t i_evt,
	input wire logic i_pin_i,
	input wire logic o_pin_o,
	input wire logic o_pin_oe,
	input wire logic o_int_n_o,
	input wire logic o_int_n_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	import tsirq_pkg::*;
	logic [15:0] low_en_reg, done_en_reg;
	logic st_rd;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// ****
	// shadow enables
	// ****
	assign st_rd = i_req.rd && (i_req.addr inside {10'h008, 10'h009, 10'h00A});
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			low_en_reg <= 16'h0000;
			done_en_reg <= 16'h0000;
		end else if (i_req.wr) begin
			if (i_req.addr == 10'h005) low_en_reg <= i_req.wdata;
			if (i_req.addr == 10'h007) done_en_reg <= i_req.wdata;
		end
	end
	// ****
	// checks
	// ****
	done_fire_a: assert property (
		|(i_evt.done & done_en_reg[11:0]) && !st_rd && !i_req.wr |=> o_int_n_oe)
		else $error("done event did not assert line");
	rd_release_a: assert property (st_rd |=> !o_int_n_oe)
		else $error("status read did not release line");
	reset_quiet_a: assert property (
		disable iff (1'h0) i_srst |=> !o_int_n_oe && !o_pin_oe && o_rd_data == 16'h0000)
		else $error("outputs active after reset");
	pin_drive_a: assert property (
		low_en_reg[13] && $stable(low_en_reg) |-> o_pin_oe && o_pin_o == low_en_reg[12])
		else $error("pin drive wrong");
	touch_chg_a: assert property (
		$changed(i_evt.low_act & low_en_reg[11:0]) && !st_rd && !i_req.wr |=> o_int_n_oe)
		else $error("touch change did not assert line");
	en_readback_a: assert property (
		i_req.rd && i_req.addr == 10'h007 |=> o_rd_data[12:0] == $past(done_en_reg[12:0]))
		else $error("enable readback wrong");
	touch_read_a: assert property (
		i_req.rd && i_req.addr == 10'h008 |=> o_rd_data == {4'h0, $past(i_evt.low_act)})
		else $error("touch status not current");
	hold_line_a: assert property (
		o_int_n_oe && !st_rd && !i_req.wr && !$past(i_req.wr) |=> o_int_n_oe)
		else $error("line dropped without read");
endmodule // tsirq_monitor

// ===== tsirq_host.sv
module tsirq_host (
	input wire logic i_int_n_o,
	input wire logic i_int_n_oe,
	input wire logic i_pin_o,
	input wire logic i_pin_oe,
	input wire logic i_pin_drv,
	output logic o_int_n,
	output logic o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// pull-up holds a released line high
	assign o_int_n = i_int_n_oe ? i_int_n_o : 1'h1;
	assign o_pin = i_pin_oe ? i_pin_o : i_pin_drv;
endmodule // tsirq_host

// ===== tsirq_tb.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import tsirq_pkg::*;
	logic i_clk = 1'h0;
	logic i_srst = 1'h1;
	tsirq_req_t req = '0;
	tsirq_evt_t evt = '0;
	logic pin_drv = 1'h0;
	logic pin_o, pin_oe, int_o, int_oe, int_w, pin_w;
	logic [15:0] rdata, rd_d, en;
	logic [11:0] dn;
	logic [1:0] tr;
	logic [31:0] seed = 32'h18EDF5AA;
	int n_fail = 0;
	int checked = 0;
	always #20 i_clk = ~i_clk;
	tsirq_top dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_req(req), .o_rd_data(rdata),
		.i_evt(evt), .i_pin_i(pin_w), .o_pin_o(pin_o), .o_pin_oe(pin_oe),
		.o_int_n_o(int_o), .o_int_n_oe(int_oe));
	tsirq_host host_u (.i_int_n_o(int_o), .i_int_n_oe(int_oe), .i_pin_o(pin_o),
		.i_pin_oe(pin_oe), .i_pin_drv(pin_drv), .o_int_n(int_w), .o_pin(pin_w));
	// ****
	// helpers
	// ****
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [15:0] exp_done(input logic [15:0] e, input logic [11:0] d);
		return {4'h0, e[11:0] & d};
	endfunction
	task automatic print_verdict();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic [9:0] a, input logic w, input logic [15:0] d);
		@(posedge i_clk);
		req <= {a, w, ~w, d};
		@(posedge i_clk);
		req <= '0;
		#1 rd_d = rdata;
	endtask
	task automatic wlow();
		int k = 0;
		#1;
		while (int_w !== 1'h0 && k < 10) begin
			@(posedge i_clk);
			#1 k++;
		end
		chk({15'h0, int_w}, 16'h0000);
		if (int_w !== 1'h0) print_verdict();
	endtask
	// ****
	// scenarios
	// ****
	initial begin
		repeat (16) @(posedge i_clk);
		i_srst <= 1'h0;
		repeat (4) begin
			seed = xs(seed);
			en = (seed[15:0] & 16'h0FFF) | 16'h0800;
			dn = seed[27:16] | 12'h800;
			acc(10'h007, 1'h1, en);
			acc(10'h007, 1'h0, 16'h0000);
			chk(rd_d & 16'h1FFF, en);
			@(posedge i_clk);
			evt.done <= dn;
			@(posedge i_clk);
			evt.done <= '0;
			wlow();
			acc(10'h00A, 1'h0, 16'h0000);
			chk(rd_d, exp_done(en, dn));
			acc(10'h00A, 1'h0, 16'h0000);
			chk(rd_d, 16'h0000);
		end
		fork
			acc(10'h00A, 1'h0, 16'h0000);
			begin
				@(posedge i_clk);
				evt.done <= 12'h800;
				@(posedge i_clk);
				evt.done <= '0;
			end
		join
		chk(rd_d, 16'h0000);
		acc(10'h00A, 1'h0, 16'h0000);
		chk(rd_d, 16'h0800);
		acc(10'h006, 1'h1, 16'h0004);
		@(posedge i_clk);
		evt.high_act <= 12'h004;
		wlow();
		acc(10'h009, 1'h0, 16'h0000);
		chk(rd_d, 16'h0004);
		@(posedge i_clk);
		evt.high_act <= 12'h000;
		wlow();
		acc(10'h009, 1'h0, 16'h0000);
		chk(rd_d, 16'h0000);
		acc(10'h005, 1'h1, 16'h0001);
		@(posedge i_clk);
		evt.low_act <= 12'h001;
		wlow();
		acc(10'h008, 1'h0, 16'h0000);
		chk(rd_d, 16'h0001);
		@(posedge i_clk);
		#1 chk({15'h0, int_w}, 16'h0001);
		@(posedge i_clk);
		evt.low_act <= 12'h000;
		wlow();
		acc(10'h008, 1'h0, 16'h0000);
		chk(rd_d, 16'h0000);
		for (int k = 0; k < 5; k++) begin
			tr = k[1:0];
			@(posedge i_clk);
			pin_drv <= ~tr[0];
			acc(10'h005, 1'h1, {tr, (k < 4) ? 2'h1 : 2'h0, 12'h000});
			acc(10'h007, 1'h1, 16'h1000);
			repeat (4) @(posedge i_clk);
			acc(10'h00A, 1'h0, 16'h0000);
			@(posedge i_clk);
			pin_drv <= tr[0];
			if (k < 4) wlow();
			repeat (6) @(posedge i_clk);
			pin_drv <= ~tr[0];
			repeat (6) @(posedge i_clk);
			acc(10'h00A, 1'h0, 16'h0000);
			chk(rd_d, (k < 4) ? 16'h1000 : 16'h0000);
			acc(10'h00A, 1'h0, 16'h0000);
			chk(rd_d, 16'h0000);
		end
		for (int t = 2; t < 4; t++) begin
			acc(10'h005, 1'h1, {2'h0, t[1:0], 12'h000});
			repeat (3) @(posedge i_clk);
			#1 chk({14'h0, pin_oe, pin_w}, {14'h0, 1'h1, t[0]});
		end
		acc(10'h00F, 1'h0, 16'h0000);
		chk(rd_d, 16'h0000);
		print_verdict();
	end
endmodule // testbench
bind tsirq_top tsirq_monitor mon_u (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req),
	.o_rd_data(o_rd_data), .i_evt(i_evt), .i_pin_i(i_pin_i), .o_pin_o(o_pin_o),
	.o_pin_oe(o_pin_oe), .o_int_n_o(o_int_n_o), .o_int_n_oe(o_int_n_oe));
